// ---- hw/wgoc_top.sv ----
`timescale 1ns/1ns
module wgoc_top
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock_i,
    input  wire logic              arst_n_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic [13:0]       data_sources_i,
    input  wire logic              gen_enable_i,
    input  wire logic [2:0]        gen_mode_i,
    input  wire logic              shutdown_cond_i,
    input  wire logic              deadband_done_i,
    output wgoc_pkg::wgoc_pins_t   wave_pins_o,
    output logic                   clk_src_hf_o,
    output logic                   generator_irq_flag_o
);
    import wgoc_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0]  out_invert;
    logic        clk_src_sel;
    logic [3:0]  data_source_sel;
    wgoc_steer_t steer;
    logic [3:0]  steer_active_en;
    logic        shutdown;
    logic        restart_en;
    logic [1:0]  bd_halt_level;
    logic [1:0]  ac_halt_level;
    logic        resume_wait;
    logic        data_in;
    logic        data_prev;
    logic        shutdown_prev;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              do_write;
    logic              wr_hit;
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata_i;
                w_lane0 <= s_axi_wstrb_i[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end
    // Registered readies: low a cycle after each take, never ahead of state
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_arready_o <= 1'b0;
        end else begin
            s_axi_awready_o <= !aw_held && !s_axi_bvalid_o && !do_write
                               && !(s_axi_awvalid_i && s_axi_awready_o);
            s_axi_wready_o  <= !w_held && !s_axi_bvalid_o && !do_write
                               && !(s_axi_wvalid_i && s_axi_wready_o);
            s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
        end
    end
    always_comb begin
        unique case (aw_addr[7:0])
            OFS_POLARITY, OFS_CLKSRC, OFS_DATASEL,
            OFS_STEER, OFS_HALT, OFS_STATUS: wr_hit = 1'b1;
            default:                         wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end
    logic wr_lane0;
    assign wr_lane0 = do_write && w_lane0;
    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // upper bits dropped
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_invert      <= '0;
            clk_src_sel     <= 1'b0;
            data_source_sel <= '0;
            steer           <= '0;
            restart_en      <= 1'b0;
            bd_halt_level   <= HALT_LVL_RESET;
            ac_halt_level   <= HALT_LVL_RESET;
        end else if (wr_lane0) begin
            unique case (aw_addr[7:0])
                OFS_POLARITY: out_invert <= w_data[3:0];
                OFS_CLKSRC:   clk_src_sel <= w_data[0];
                OFS_DATASEL:  data_source_sel <= w_data[3:0];
                OFS_STEER:    steer <= w_data[7:0];
                OFS_HALT: begin
                    restart_en    <= w_data[POS_RESTART];
                    bd_halt_level <= w_data[POS_BD_LO +: 2];
                    ac_halt_level <= w_data[POS_AC_LO +: 2];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data input selection and edge
    // ------------------------------------------------------------
    logic data_rise;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_in   <= 1'b0;
            data_prev <= 1'b0;
        end else begin
            data_in   <= (data_source_sel <= SRC_LAST) ?
                         data_sources_i[data_source_sel] : 1'b0;
            data_prev <= data_in;
        end
    end
    assign data_rise = data_in && !data_prev;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_src_hf_o <= 1'b0;
        end else begin
            clk_src_hf_o <= clk_src_sel;
        end
    end
    // ------------------------------------------------------------
    // Steering enable buffering
    // ------------------------------------------------------------
    // sync mode loads on edge
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            steer_active_en <= '0;
        end else if (gen_mode_i != MODE_SYNC_STEER || data_rise) begin
            steer_active_en <= steer.en;
        end
    end
    // ------------------------------------------------------------
    // Shutdown status
    // ------------------------------------------------------------
    logic sw_wr_halt;
    assign sw_wr_halt = wr_lane0 && aw_addr[7:0] == OFS_HALT;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shutdown <= 1'b0;
        end else if (shutdown_cond_i) begin
            shutdown <= 1'b1;
        end else if (sw_wr_halt && w_data[POS_SHUTDOWN]) begin
            shutdown <= 1'b1;
        end else if (restart_en) begin
            shutdown <= 1'b0;
        end else if (sw_wr_halt) begin
            shutdown <= 1'b0;
        end
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            resume_wait <= 1'b0;
        end else if (shutdown) begin
            resume_wait <= 1'b1;
        end else if (data_rise) begin
            resume_wait <= 1'b0;
        end
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shutdown_prev        <= 1'b0;
            generator_irq_flag_o <= 1'b0;
        end else begin
            shutdown_prev        <= shutdown;
            generator_irq_flag_o <= shutdown && !shutdown_prev;
        end
    end
    // ------------------------------------------------------------
    // Output conditioning
    // ------------------------------------------------------------
    wgoc_pins_t next_pins;
    logic       halted;
    logic       steer_mode;
    logic [1:0] lvl;
    assign halted     = shutdown || resume_wait;
    assign steer_mode = gen_mode_i == MODE_ASYNC_STEER || gen_mode_i == MODE_SYNC_STEER;
    always_comb begin
        next_pins = '0;
        lvl       = LVL_TRI;
        for (int i = 0; i < 4; i++) begin
            // odd outputs are B and D
            lvl = i[0] ? bd_halt_level : ac_halt_level;
            if (halted) begin
                unique case (lvl)
                    LVL_HIGH: begin
                        next_pins.drive[i] = 1'b1;
                        next_pins.oe[i]    = 1'b1;
                    end
                    LVL_LOW: begin
                        next_pins.drive[i] = 1'b0;
                        next_pins.oe[i]    = 1'b1;
                    end
                    LVL_TRI: ;
                    LVL_INACTIVE: begin
                        next_pins.drive[i] = out_invert[i];
                        next_pins.oe[i]    = deadband_done_i;
                    end
                endcase
            end else if (steer_mode && !steer_active_en[i]) begin
                next_pins.drive[i] = steer.value[i];
                next_pins.oe[i]    = gen_enable_i;
            end else begin
                next_pins.drive[i] = data_in ^ out_invert[i];
                next_pins.oe[i]    = gen_enable_i;
            end
        end
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wave_pins_o <= '0;
        end else begin
            wave_pins_o <= next_pins;
        end
    end
    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_byte = '0;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr_i[7:0])
            OFS_POLARITY: rd_byte = {2'h0, data_in, 1'b0, out_invert};
            OFS_CLKSRC:   rd_byte = {7'h00, clk_src_sel};
            OFS_DATASEL:  rd_byte = {4'h0, data_source_sel};
            OFS_STEER:    rd_byte = steer;
            OFS_HALT:     rd_byte = {shutdown, restart_en, bd_halt_level,
                                     ac_halt_level, 2'h0};
            OFS_STATUS:   rd_byte = {4'h0, steer_active_en};
            default:      rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= AXI_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= {24'h000000, rd_byte};
            s_axi_rresp_o  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    a_irq_on_set: assert property ($rose(shutdown) |=> generator_irq_flag_o)
        else $error("irq flag missing after shutdown set");
    a_cond_holds: assert property (shutdown_cond_i |=> shutdown)
        else $error("shutdown cleared while condition active");
    a_auto_clear: assert property (shutdown && restart_en && !shutdown_cond_i
        && !sw_wr_halt |=> !shutdown)
        else $error("auto restart did not clear shutdown");
    a_halt_tri: assert property (shutdown && ac_halt_level == LVL_TRI
        |=> !wave_pins_o.oe[0] && !wave_pins_o.oe[2])
        else $error("A/C not tri-stated");
    a_halt_high_bd: assert property (shutdown && bd_halt_level == LVL_HIGH
        |=> wave_pins_o.drive[1] && wave_pins_o.oe[1])
        else $error("B not high in shutdown");
    a_resume_wait: assert property ($fell(shutdown) && !data_rise
        |-> resume_wait)
        else $error("outputs resumed before data edge");
    a_invert_a: assert property (!halted && !steer_mode
        |=> wave_pins_o.drive[0] == ($past(data_in) ^ $past(out_invert[0])))
        else $error("polarity wrong on A");
    a_static_val: assert property (!halted && steer_mode && !steer_active_en[3]
        |=> wave_pins_o.drive[3] == $past(steer.value[3]))
        else $error("static steering value wrong");
    a_sync_hold: assert property (gen_mode_i == MODE_SYNC_STEER && !data_rise
        |=> $stable(steer_active_en))
        else $error("sync steering applied without edge");

    c_shutdown: cover property ($rose(shutdown));
    c_resume: cover property ($fell(resume_wait));
    c_sync_load: cover property (gen_mode_i == MODE_SYNC_STEER && data_rise);
endmodule

// ---- hw/wgoc_pkg.sv ----
package wgoc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_POLARITY = 8'h00;
    localparam logic [7:0] OFS_CLKSRC   = 8'h04;
    localparam logic [7:0] OFS_DATASEL  = 8'h08;
    localparam logic [7:0] OFS_STEER    = 8'h0c;
    localparam logic [7:0] OFS_HALT     = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_IN_LEVEL = 5;
    localparam int POS_SHUTDOWN = 7;
    localparam int POS_RESTART  = 6;
    localparam int POS_BD_LO    = 4;
    localparam int POS_AC_LO    = 2;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HALT_LVL_RESET = 2'h1;
    localparam logic [1:0] LVL_HIGH       = 2'h3;
    localparam logic [1:0] LVL_LOW        = 2'h2;
    localparam logic [1:0] LVL_TRI        = 2'h1;
    localparam logic [1:0] LVL_INACTIVE   = 2'h0;
    localparam logic [3:0] SRC_LAST       = 4'hd;
    localparam logic [1:0] AXI_OKAY       = 2'h0;
    localparam logic [1:0] AXI_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        MODE_ASYNC_STEER = 3'b000,
        MODE_SYNC_STEER  = 3'b001,
        MODE_FWD_FULL    = 3'b010,
        MODE_REV_FULL    = 3'b011,
        MODE_HALF        = 3'b100,
        MODE_PUSH_PULL   = 3'b101
    } wgoc_mode_t;

    typedef struct packed {
        logic [3:0] value;
        logic [3:0] en;
    } wgoc_steer_t;

    typedef struct packed {
        logic [3:0] drive;
        logic [3:0] oe;
    } wgoc_pins_t;
endpackage

// ---- bench/wgoc_gate_drv_model.sv ----
`timescale 1ns/1ns
module wgoc_gate_drv_model (
    input  wire logic                 clock_i,
    input  wire wgoc_pkg::wgoc_pins_t pins_i,
    output logic [3:0]                level_o
);
    import wgoc_pkg::*;
    logic [3:0] last = 4'h0;
    // ------------------------------------------------------------
    // Gate driver inputs
    // ------------------------------------------------------------
    // No pull on the driver inputs: a released line toggles, never holds
    assign level_o = (pins_i.oe & pins_i.drive) | (~pins_i.oe & ~last);
    always_ff @(posedge clock_i) begin
        last <= level_o;
    end
endmodule

// ---- bench/waveform_gen_output_control_tb_top.sv ----
`timescale 1ns/1ns
module waveform_gen_output_control_tb_top;
    import wgoc_pkg::*;
    logic        clock = 1'h0;
    logic        arst_n = 1'h0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, hf, irq;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [13:0] src = 14'h0;
    logic        gen_en = 1'h1, cond = 1'h0, db_done = 1'h0;
    logic [2:0]  mode = 3'h0;
    wgoc_pins_t  pins;
    logic [3:0]  level;
    int          n_mismatch = 0, total_checks = 0, n_irq = 0, cycles = 0, base = 0;

    wgoc_top u_dut (.clock_i(clock), .arst_n_i(arst_n), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .data_sources_i(src), .gen_enable_i(gen_en),
        .gen_mode_i(mode), .shutdown_cond_i(cond), .deadband_done_i(db_done),
        .wave_pins_o(pins), .clk_src_hf_o(hf), .generator_irq_flag_o(irq));
    wgoc_gate_drv_model u_model (.clock_i(clock), .pins_i(pins), .level_o(level));

    always #20 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (irq === 1'h1) n_irq++;
        if (cycles == 6000) begin
            n_mismatch++;
            $display("BAD timeout expected 0 seen 1");
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p, w_p;
        aw_p = 1'h1;
        w_p = 1'h1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (aw_p || w_p) begin
            @(posedge clock);
            if (aw_p && awready === 1'h1) begin
                aw_p = 1'h0;
                awvalid <= 1'h0;
            end
            if (w_p && wready === 1'h1) begin
                w_p = 1'h0;
                wvalid <= 1'h0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'h1);
        rsp = bresp;
        bready <= 1'h0;
        cyc(2);
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clock); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge clock); while (rvalid !== 1'h1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'h0;
        cyc(1);
    endtask
    function automatic logic [3:0] sx(logic d, logic [3:0] en, logic [3:0] v, logic [3:0] inv);
        return (en & ({4{d}} ^ inv)) | (~en & v);
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int a = 0; a <= 8'h14; a += 4) begin
            rdr(8'(a));
            chk("reset value", (a == OFS_HALT) ? 32'h14 : 32'h0, rd);
        end
        $display("test reset done");
    endtask
    task automatic t_regs();
        src <= 14'h1;
        wr(OFS_POLARITY, 32'hffffffff);
        rdr(OFS_POLARITY);
        chk("polarity", 32'h2f, rd);
        wr(OFS_CLKSRC, 32'hffffffff);
        rdr(OFS_CLKSRC);
        chk("clock select", 32'h1, rd);
        chk("hf select", 32'h1, {31'h0, hf});
        wr(OFS_CLKSRC, 32'h0);
        chk("hf select", 32'h0, {31'h0, hf});
        wr(OFS_DATASEL, 32'hffffffff);
        rdr(OFS_DATASEL);
        chk("data select", 32'hf, rd);
        wr(OFS_HALT, 32'h3);
        rdr(OFS_HALT);
        chk("halt low bits", 32'h0, rd);
        wr(8'h18, 32'h1);
        chk("unmapped write", {30'h0, AXI_SLVERR}, {30'h0, rsp});
        rdr(8'h18);
        chk("unmapped read", {30'h0, AXI_SLVERR}, {30'h0, rsp});
        $display("test registers done");
    endtask
    task automatic t_select();
        for (int k = 0; k < 16; k++) begin
            wr(OFS_DATASEL, 32'(k));
            src <= (k < 14) ? (14'h1 << k) : 14'h3fff;
            cyc(3);
            rdr(OFS_POLARITY);
            chk("selected level", (k < 14) ? 32'h2f : 32'hf, rd);
        end
        wr(OFS_DATASEL, 32'h0);
        $display("test select done");
    endtask
    task automatic t_steer();
        wr(OFS_POLARITY, 32'h3);
        wr(OFS_STEER, 32'ha5);
        for (int d = 0; d < 2; d++) begin
            mode <= 3'h0;
            src <= 14'(d);
            cyc(3);
            chk("steer pins", {24'h0, sx(d[0], 4'h5, 4'ha, 4'h3), 4'hf}, pins);
            mode <= 3'h2;
            cyc(3);
            chk("full pins", {24'h0, {4{d[0]}} ^ 4'h3, 4'hf}, pins);
        end
        $display("test steering done");
    endtask
    task automatic t_sync();
        mode <= 3'h1;
        src <= 14'h0;
        cyc(3);
        wr(OFS_STEER, 32'haf);
        cyc(2);
        rdr(OFS_STATUS);
        chk("held enables", 32'h5, rd);
        chk("held pins", {24'h0, sx(1'h0, 4'h5, 4'ha, 4'h3), 4'hf}, pins);
        src <= 14'h1;
        cyc(4);
        rdr(OFS_STATUS);
        chk("loaded enables", 32'hf, rd);
        chk("loaded pins", {24'h0, sx(1'h1, 4'hf, 4'ha, 4'h3), 4'hf}, pins);
        $display("test sync steering done");
    endtask
    task automatic t_halt();
        mode <= 3'h2;
        src <= 14'h0;
        wr(OFS_HALT, 32'h38);
        base = n_irq;
        cond <= 1'h1;
        cyc(4);
        chk("irq pulses", 32'h1, 32'(n_irq - base));
        rdr(OFS_HALT);
        chk("shutdown set", 32'hb8, rd);
        chk("halt pins", 32'haf, {24'h0, pins});
        chk("gate levels", 32'ha, {28'h0, level});
        wr(OFS_HALT, 32'h38);
        rdr(OFS_HALT);
        chk("refused clear", 32'hb8, rd);
        wr(OFS_HALT, 32'h14);
        chk("tri pins", 32'h0, {28'h0, pins.oe});
        db_done <= 1'h0;
        wr(OFS_HALT, 32'h0);
        chk("inactive wait", 32'h30, {24'h0, pins});
        db_done <= 1'h1;
        cyc(3);
        chk("inactive pins", 32'h3f, {24'h0, pins});
        wr(OFS_HALT, 32'hb8);
        cond <= 1'h0;
        cyc(4);
        rdr(OFS_HALT);
        chk("no restart", 32'hb8, rd);
        wr(OFS_HALT, 32'h38);
        rdr(OFS_HALT);
        chk("sw clear", 32'h38, rd);
        chk("hold pins", 32'haf, {24'h0, pins});
        src <= 14'h1;
        cyc(4);
        chk("resume pins", 32'hcf, {24'h0, pins});
        $display("test shutdown done");
    endtask
    task automatic t_auto();
        src <= 14'h0;
        wr(OFS_HALT, 32'h78);
        base = n_irq;
        cond <= 1'h1;
        cyc(4);
        rdr(OFS_HALT);
        chk("auto set", 32'hf8, rd);
        cond <= 1'h0;
        cyc(4);
        rdr(OFS_HALT);
        chk("auto clear", 32'h78, rd);
        chk("auto hold", 32'haf, {24'h0, pins});
        chk("irq pulses", 32'h1, 32'(n_irq - base));
        $display("test auto restart done");
    endtask
    task automatic t_swset();
        gen_en <= 1'h0;
        base = n_irq;
        wr(OFS_HALT, 32'hb8);
        cyc(4);
        rdr(OFS_HALT);
        chk("sw set", 32'hb8, rd);
        chk("sw set pins", 32'haf, {24'h0, pins});
        chk("irq pulses", 32'h1, 32'(n_irq - base));
        wr(OFS_HALT, 32'h38);
        gen_en <= 1'h1;
        $display("test software set done");
    endtask

    // ------------------------------------------------------------
    // Run and verdict
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1'h1;
        @(posedge clock);
        t_reset();
        t_regs();
        t_select();
        t_steer();
        t_sync();
        t_halt();
        t_auto();
        t_swset();
        summarize();
    end
endmodule
